// *** fb_status_control.sv ***
// Purpose: fieldbus status word builder and alternative control word decoder
// Assumes: all state inputs synchronous to clk; speed values unsigned magnitudes
// Notes:   status word refreshed every cycle, one cycle behind its inputs; inhibit bit 6 two cycles behind
//
// How it works
// - bit 0 shows ready to switch on
// - bit 1 shows ready to run
// - bit 2 running, modulating, flux, brake open when brake feedback used
// - bit 3 shows fault state
// - bit 4 low while coast stop present
// - bit 5 low while quick stop present
// - inhibit clears after stops released, off, on
// - bit 7 follows warning, unlatched
// - bit 8 speed within tolerance of reference
// - bit 9 fieldbus control active
// - bit 10 speed at or above limit
// - control bit 11 echoed to status 15
// - alt word: start/stop and direction bits
// - alt word: fault reset on rising edge
// - coast stop forces switch-on inhibit
`timescale 1ns/1ps
module fb_status_control #(
    parameter int SPEED_W = fb_word_pkg::SPEED_W
) (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            srst,
    // primary control word from the master
    input  wire logic [fb_word_pkg::WORD_W-1:0]  controlWord,
    // alternative control word from the master
    input  wire logic [fb_word_pkg::WORD_W-1:0]  simpleMainControlWord,
    // drive internal state
    input  wire logic                            readyOn,
    input  wire logic                            readyRun,
    input  wire logic                            runState,
    input  wire logic                            modulating,
    input  wire logic                            fluxReady,
    input  wire logic                            brakeFbUsed,
    input  wire logic                            brakeOpen,
    input  wire logic                            faultState,
    input  wire logic                            faultTrip,
    input  wire logic                            warning,
    input  wire logic                            fbControlActive,
    // speed supervision
    input  wire logic [SPEED_W-1:0]              speedActual,
    input  wire logic [SPEED_W-1:0]              speedRef,
    input  wire logic [SPEED_W-1:0]              speedTolerance,
    input  wire logic [SPEED_W-1:0]              aboveSpeedLimitSetting,
    // status word to the master
    output logic      [fb_word_pkg::WORD_W-1:0]  driveStatusWord,
    // decoded alternative commands
    output logic                                 startReq,
    output logic                                 dirCcw,
    output logic                                 faultResetPulse
);
    logic [fb_word_pkg::WORD_W-1:0] statusReg;     // registered status word
    logic [fb_word_pkg::WORD_W-1:0] statusNext;
    logic                           startReg;      // registered start request
    logic                           startNext;
    logic                           ccwReg;        // registered direction
    logic                           ccwNext;
    logic                           prevResetReg;  // last fault-reset bit seen
    logic                           prevResetNext;
    logic                           pulseReg;      // one-cycle fault reset
    logic                           pulseNext;
    logic [SPEED_W-1:0]             speedErr;

    fb_inhibit_if inh ();

    // absolute difference, kept as a function for reuse
    function automatic logic [SPEED_W-1:0] absDiff(input logic [SPEED_W-1:0] a,
                                                   input logic [SPEED_W-1:0] b);
        absDiff = (a >= b) ? (a - b) : (b - a);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // inhibit tracker wiring
    assign inh.onCmd     = controlWord[fb_word_pkg::CW_ON];
    assign inh.noCoast   = controlWord[fb_word_pkg::CW_NO_COAST];
    assign inh.noQstop   = controlWord[fb_word_pkg::CW_NO_QSTOP];
    assign inh.faultTrip = faultTrip;

    fb_inhibit_tracker uInhibit (
        .clk  (clk),
        .srst (srst),
        .io   (inh.tracker)
    );

    ////////////////////////////////////////////////////////////////////
    // status word next value, rebuilt fully each cycle
    always_comb begin
        speedErr = absDiff(speedActual, speedRef);
        statusNext = fb_word_pkg::STATUS_RESET;
        statusNext[fb_word_pkg::ST_RDY_ON] = readyOn;
        statusNext[fb_word_pkg::ST_RDY_RUN] = readyRun;
        // brake only gates running when its feedback is wired
        statusNext[fb_word_pkg::ST_RUNNING] = runState && modulating && fluxReady
                                              && (!brakeFbUsed || brakeOpen);
        statusNext[fb_word_pkg::ST_FAULT] = faultState;
        statusNext[fb_word_pkg::ST_NO_COAST] = controlWord[fb_word_pkg::CW_NO_COAST];
        statusNext[fb_word_pkg::ST_NO_QSTOP] = controlWord[fb_word_pkg::CW_NO_QSTOP];
        statusNext[fb_word_pkg::ST_INHIBIT] = inh.inhibit;
        statusNext[fb_word_pkg::ST_WARN] = warning;
        statusNext[fb_word_pkg::ST_AT_REF] = (speedErr <= speedTolerance);
        statusNext[fb_word_pkg::ST_FB_CTRL] = fbControlActive;
        statusNext[fb_word_pkg::ST_ABOVE] = (speedActual >= aboveSpeedLimitSetting);
        // watchdog timing is the master's job; only the echo lives here
        statusNext[fb_word_pkg::ST_WD_ECHO] = controlWord[fb_word_pkg::CW_WD];
    end

    // alternative control word decode; upper bits deliberately ignored
    always_comb begin
        startNext = simpleMainControlWord[fb_word_pkg::AC_START];
        ccwNext = simpleMainControlWord[fb_word_pkg::AC_CCW];
        prevResetNext = simpleMainControlWord[fb_word_pkg::AC_FRESET];
        // a held level must not retrigger, only a zero-to-one step
        pulseNext = simpleMainControlWord[fb_word_pkg::AC_FRESET] && !prevResetReg;
    end

    // registers; edge memory cleared, so a fault-reset bit already high at startup gives one pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            statusReg <= fb_word_pkg::STATUS_RESET;
            startReg <= 1'b0;
            ccwReg <= 1'b0;
            prevResetReg <= 1'b0;
            pulseReg <= 1'b0;
        end else begin
            statusReg <= statusNext;
            startReg <= startNext;
            ccwReg <= ccwNext;
            prevResetReg <= prevResetNext;
            pulseReg <= pulseNext;
        end
    end

    assign driveStatusWord = statusReg;
    assign startReq = startReg;
    assign dirCcw = ccwReg;
    assign faultResetPulse = pulseReg;

    ////////////////////////////////////////////////////////////////////
    // checks
    // reset is released by the same edge that starts the first attempt, so the
    // sampled srst also gates antecedents whose answer would still be the reset value
    property p_readyOn;
        @(posedge clk) disable iff (srst)
        !srst |=> driveStatusWord[fb_word_pkg::ST_RDY_ON] == $past(readyOn);
    endproperty
    a_readyOn: assert property (p_readyOn) else $error("ready-on bit wrong");
    property p_readyRun;
        @(posedge clk) disable iff (srst)
        !srst |=> driveStatusWord[fb_word_pkg::ST_RDY_RUN] == $past(readyRun);
    endproperty
    a_readyRun: assert property (p_readyRun) else $error("ready-run bit wrong");
    property p_running;
        @(posedge clk) disable iff (srst)
        !fluxReady |=> !driveStatusWord[fb_word_pkg::ST_RUNNING];
    endproperty
    a_running: assert property (p_running) else $error("running without flux");
    property p_fault;
        @(posedge clk) disable iff (srst)
        !srst && faultState |=> driveStatusWord[fb_word_pkg::ST_FAULT];
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit missing");
    property p_coast;
        @(posedge clk) disable iff (srst)
        !controlWord[fb_word_pkg::CW_NO_COAST] |=> !driveStatusWord[fb_word_pkg::ST_NO_COAST];
    endproperty
    a_coast: assert property (p_coast) else $error("coast bit sense wrong");
    property p_qstop;
        @(posedge clk) disable iff (srst)
        !srst && controlWord[fb_word_pkg::CW_NO_QSTOP] |=> driveStatusWord[fb_word_pkg::ST_NO_QSTOP];
    endproperty
    a_qstop: assert property (p_qstop) else $error("quick stop bit sense wrong");
    property p_warn;
        @(posedge clk) disable iff (srst)
        $fell(warning) |=> !driveStatusWord[fb_word_pkg::ST_WARN];
    endproperty
    a_warn: assert property (p_warn) else $error("warning latched");
    property p_above;
        @(posedge clk) disable iff (srst)
        (speedActual < aboveSpeedLimitSetting) |=> !driveStatusWord[fb_word_pkg::ST_ABOVE];
    endproperty
    a_above: assert property (p_above) else $error("above-limit set below limit");
    property p_echo;
        @(posedge clk) disable iff (srst)
        !srst && $rose(controlWord[fb_word_pkg::CW_WD]) |=> driveStatusWord[fb_word_pkg::ST_WD_ECHO];
    endproperty
    a_echo: assert property (p_echo) else $error("watchdog not echoed");
    property p_unused;
        @(posedge clk) disable iff (srst)
        driveStatusWord[fb_word_pkg::ST_WD_ECHO-1:fb_word_pkg::ST_ABOVE+1] == '0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bits set");
    property p_edge;
        @(posedge clk) disable iff (srst)
        faultResetPulse |=> !faultResetPulse;
    endproperty
    a_edge: assert property (p_edge) else $error("fault reset repeated on level");
    // equal speeds are inside any tolerance, so the bit must follow
    property p_atRef;
        @(posedge clk) disable iff (srst)
        !srst && (speedActual == speedRef) |=> driveStatusWord[fb_word_pkg::ST_AT_REF];
    endproperty
    a_atRef: assert property (p_atRef) else $error("at-reference bit missing");
    property p_fbCtrl;
        @(posedge clk) disable iff (srst)
        !srst |=> driveStatusWord[fb_word_pkg::ST_FB_CTRL] == $past(fbControlActive);
    endproperty
    a_fbCtrl: assert property (p_fbCtrl) else $error("fieldbus control bit wrong");
    property p_warnOn;
        @(posedge clk) disable iff (srst)
        !srst && warning |=> driveStatusWord[fb_word_pkg::ST_WARN];
    endproperty
    a_warnOn: assert property (p_warnOn) else $error("warning not shown");
    property p_start;
        @(posedge clk) disable iff (srst)
        !srst |=> startReq == $past(simpleMainControlWord[fb_word_pkg::AC_START]);
    endproperty
    a_start: assert property (p_start) else $error("start request wrong");
    property p_dir;
        @(posedge clk) disable iff (srst)
        !srst |=> dirCcw == $past(simpleMainControlWord[fb_word_pkg::AC_CCW]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    // main scenarios seen at least once
    c_faultReset: cover property (@(posedge clk) disable iff (srst) faultResetPulse);
    c_atRef: cover property (@(posedge clk) disable iff (srst) driveStatusWord[fb_word_pkg::ST_AT_REF]);
    c_running: cover property (@(posedge clk) disable iff (srst) driveStatusWord[fb_word_pkg::ST_RUNNING]);
endmodule

// *** fb_word_pkg.sv ***
// Purpose: constants shared by the fieldbus status/control word block
// Assumes: 16-bit process data words
// Notes:   bit positions, word widths, status reset value and inhibit states; no register offsets exist on this interface
package fb_word_pkg;
    localparam int WORD_W = 16;
    localparam int SPEED_W = 16;
    // status word bit positions
    localparam int ST_RDY_ON = 0;
    localparam int ST_RDY_RUN = 1;
    localparam int ST_RUNNING = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_NO_COAST = 4;
    localparam int ST_NO_QSTOP = 5;
    localparam int ST_INHIBIT = 6;
    localparam int ST_WARN = 7;
    localparam int ST_AT_REF = 8;
    localparam int ST_FB_CTRL = 9;
    localparam int ST_ABOVE = 10;
    localparam int ST_WD_ECHO = 15;
    // primary control word bit positions
    localparam int CW_ON = 0;
    localparam int CW_NO_COAST = 1;
    localparam int CW_NO_QSTOP = 2;
    localparam int CW_WD = 11;
    // alternative control word bit positions
    localparam int AC_START = 0;
    localparam int AC_CCW = 1;
    localparam int AC_FRESET = 2;
    localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
    // switch-on-inhibit tracker states
    typedef enum logic [1:0] {
        INH_CLEAR = 2'b00,
        INH_SET   = 2'b01,
        INH_ARMED = 2'b11
    } inhibit_e;
endpackage

// *** fb_inhibit_if.sv ***
// Purpose: carrier between the status builder and the inhibit tracker
// Assumes: single clock domain
// Notes:   commands in, inhibit level out
`timescale 1ns/1ps
interface fb_inhibit_if;
    logic onCmd;     // primary control word on bit
    logic noCoast;   // high when no coast stop commanded
    logic noQstop;   // high when no quick stop commanded
    logic faultTrip; // fault reaction isolated the output
    logic inhibit;   // switch-on inhibited
    modport tracker (input onCmd, input noCoast, input noQstop, input faultTrip, output inhibit);
    modport user (output onCmd, output noCoast, output noQstop, output faultTrip, input inhibit);
endinterface

// *** fb_inhibit_tracker.sv ***
// Purpose: switch-on-inhibit state tracking
// Assumes: commands synchronous to clk
// Notes:   clears only after both stops released, then off, then on
`timescale 1ns/1ps
module fb_inhibit_tracker (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // commands and result
    fb_inhibit_if.tracker    io
);
    fb_word_pkg::inhibit_e stateReg;
    fb_word_pkg::inhibit_e stateNext;
    logic                  bothFree;

    ////////////////////////////////////////////////////////////////////
    // next state: coast stop or fault always re-enters inhibit
    always_comb begin
        bothFree = io.noCoast && io.noQstop;
        stateNext = stateReg;
        unique case (stateReg)
            fb_word_pkg::INH_CLEAR: begin
                if (!io.noCoast || io.faultTrip) begin
                    stateNext = fb_word_pkg::INH_SET;
                end
            end
            fb_word_pkg::INH_SET: begin
                // off seen after both stops released arms the release
                if (bothFree && !io.onCmd) begin
                    stateNext = fb_word_pkg::INH_ARMED;
                end
            end
            fb_word_pkg::INH_ARMED: begin
                if (!bothFree || io.faultTrip) begin
                    stateNext = fb_word_pkg::INH_SET;
                end else if (io.onCmd) begin
                    stateNext = fb_word_pkg::INH_CLEAR;
                end
            end
            default: stateNext = fb_word_pkg::INH_SET;
        endcase
    end

    // registers; inhibit asserted out of reset is not wanted, so start clear
    always_ff @(posedge clk) begin
        if (srst) begin
            stateReg <= fb_word_pkg::INH_CLEAR;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign io.inhibit = (stateReg != fb_word_pkg::INH_CLEAR);

    ////////////////////////////////////////////////////////////////////
    property p_inhRelease;
        @(posedge clk) disable iff (srst)
        !srst && (stateReg == fb_word_pkg::INH_SET) |=> (stateReg != fb_word_pkg::INH_CLEAR);
    endproperty
    a_inhRelease: assert property (p_inhRelease) else $error("inhibit cleared without off step");
    property p_coastInhibit;
        @(posedge clk) disable iff (srst)
        // sampled srst keeps the release edge out: state is still clear one edge later
        !srst && !io.noCoast |=> io.inhibit;
    endproperty
    a_coastInhibit: assert property (p_coastInhibit) else $error("coast stop did not inhibit");
    c_release: cover property (@(posedge clk) disable iff (srst)
        (stateReg == fb_word_pkg::INH_ARMED) ##1 (stateReg == fb_word_pkg::INH_CLEAR));
endmodule

// *** fb_master_model.sv ***
// Purpose: fieldbus master model driving cyclic control words
// Assumes: words change just after a rising clock edge
// Notes:   watchdog half period shortened to WD_HALF cycles
`timescale 1ns/1ps
module fb_master_model #(
    parameter int WD_HALF = 20 // stands in for half a second
) (
    // clock
    input  wire logic                           clk,
    // process data to the drive
    output logic      [fb_word_pkg::WORD_W-1:0] controlWord,
    output logic      [fb_word_pkg::WORD_W-1:0] simpleMainControlWord
);
    logic [fb_word_pkg::WORD_W-1:0] cwBits;  // bits other than the watchdog
    logic                           wdLevel; // watchdog square wave
    int                             wdCount; // cycles into the half period
    initial begin
        cwBits = 16'h0000;
        wdLevel = 1'b0;
        wdCount = 0;
        simpleMainControlWord = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    // the watchdog runs through reset too, as a live master would
    always @(posedge clk) begin
        wdCount <= (wdCount == WD_HALF - 1) ? 0 : wdCount + 1;
        if (wdCount == WD_HALF - 1) begin
            wdLevel <= ~wdLevel;
        end
    end
    // watchdog merged into its bit position
    always_comb begin
        controlWord = cwBits;
        controlWord[fb_word_pkg::CW_WD] = wdLevel;
    end
    ////////////////////////////////////////////////////////////////
    // the sequence of stop, off and on words is the caller's job
    task automatic setCw(input logic [15:0] value);
        @(posedge clk);
        cwBits <= value;
    endtask
    // fault reset is a level here; only its rising edge acts
    task automatic setAlt(input logic [15:0] value);
        @(posedge clk);
        simpleMainControlWord <= value;
    endtask
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the status word block
// Assumes: one clock, expectations rebuilt each edge
// Notes:   outputs compared every falling edge
`timescale 1ns/1ps
module tb;
    logic                   clk;
    logic                   srst;
    logic [15:0]            controlWord, simpleMainControlWord;
    logic [10:0]            st;        // drive state flags, port order
    logic [15:0]            act, refSpd, tol, lim;
    logic [15:0]            driveStatusWord, expWord;
    logic                   startReq, dirCcw, faultResetPulse;
    logic                   expStart, expDir, expPulse, prevReset;
    fb_word_pkg::inhibit_e  inhState;  // mirror of the inhibit tracker
    int                     errCount, nCompared, cycles;
    logic                   checking;  // off until the first reset edges
    fb_master_model fb_master_model_inst (.clk(clk), .controlWord(controlWord),
        .simpleMainControlWord(simpleMainControlWord));
    fb_status_control fb_status_control_inst (.clk(clk), .srst(srst), .controlWord(controlWord),
        .simpleMainControlWord(simpleMainControlWord), .readyOn(st[0]), .readyRun(st[1]),
        .runState(st[2]), .modulating(st[3]), .fluxReady(st[4]), .brakeFbUsed(st[5]),
        .brakeOpen(st[6]), .faultState(st[7]), .faultTrip(st[8]), .warning(st[9]),
        .fbControlActive(st[10]), .speedActual(act), .speedRef(refSpd), .speedTolerance(tol),
        .aboveSpeedLimitSetting(lim), .driveStatusWord(driveStatusWord), .startReq(startReq),
        .dirCcw(dirCcw), .faultResetPulse(faultResetPulse));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // inhibit: coast stop or trip sets it; stops free plus off arms it
    function automatic fb_word_pkg::inhibit_e nextInh(input fb_word_pkg::inhibit_e cur,
                                                      input logic [15:0] cw, input logic trip);
        if (!cw[1] || trip) return fb_word_pkg::INH_SET;
        if (cur == fb_word_pkg::INH_CLEAR) return cur;
        if (!cw[2]) return fb_word_pkg::INH_SET;
        if (cur == fb_word_pkg::INH_SET) return cw[0] ? cur : fb_word_pkg::INH_ARMED;
        return cw[0] ? fb_word_pkg::INH_CLEAR : cur;
    endfunction
    // expected outputs, one edge behind the inputs like the design; inhibit bit two edges behind
    always @(posedge clk) begin
        if (srst) begin
            inhState <= fb_word_pkg::INH_CLEAR;
            expWord <= 16'h0000;
            {expStart, expDir, expPulse, prevReset} <= 4'h0;
        end else begin
            inhState <= nextInh(inhState, controlWord, st[8]);
            expWord <= {controlWord[11], 4'h0, act >= lim, st[10],
                ((act > refSpd) ? act - refSpd : refSpd - act) <= tol, st[9],
                inhState != fb_word_pkg::INH_CLEAR, controlWord[2:1], st[7],
                st[2] & st[3] & st[4] & (~st[5] | st[6]), st[1:0]};
            {expStart, expDir} <= {simpleMainControlWord[0], simpleMainControlWord[1]};
            expPulse <= simpleMainControlWord[2] & ~prevReset;
            prevReset <= simpleMainControlWord[2];
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // outputs are settled by the falling edge
    always @(negedge clk) begin
        if (checking) begin
            checkWord(driveStatusWord, expWord);
            checkBit(startReq, expStart);
            checkBit(dirCcw, expDir);
            checkBit(faultResetPulse, expPulse);
        end
    end
    task automatic tallyAndFinish;
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errCount++;
            tallyAndFinish();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic hold(input logic [10:0] flags);
        @(posedge clk);
        st <= flags;
        repeat (3) @(posedge clk);
    endtask
    task automatic spd(input logic [15:0] a, input logic [15:0] r, input logic [15:0] t, input logic [15:0] l);
        @(posedge clk);
        {act, refSpd, tol, lim} <= {a, r, t, l};
        repeat (2) @(posedge clk);
    endtask
    task automatic cw(input logic [15:0] value);
        fb_master_model_inst.setCw(value);
        repeat (3) @(posedge clk);
    endtask
    initial begin
        srst = 1'b1;
        st = 11'h000;
        {act, refSpd, tol, lim} = 64'h0;
        errCount = 0;
        nCompared = 0;
        cycles = 0;
        checking = 1'b0;
        repeat (2) @(posedge clk);
        checking <= 1'b1;
        repeat (14) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 11; i++) hold(11'h001 << i);
        hold(11'h01c);
        hold(11'h03c);
        hold(11'h07c);
        spd(16'h0064, 16'h0064, 16'h0000, 16'h0065);
        spd(16'h0069, 16'h0064, 16'h0005, 16'h0069);
        spd(16'h005e, 16'h0064, 16'h0005, 16'h005f);
        spd(16'hffff, 16'h0000, 16'hffff, 16'hffff);
        for (int i = 0; i < 8; i++) begin
            fb_master_model_inst.setAlt(16'hfff8 | 16'(i));
            repeat (2) @(posedge clk);
        end
        fb_master_model_inst.setAlt(16'h0000);
        fb_master_model_inst.setAlt(16'h0004);
        cw(16'h0000);
        cw(16'h0006);
        cw(16'h0002);
        cw(16'h0006);
        cw(16'h0007);
        cw(16'h0003);
        cw(16'h0007);
        hold(11'h100);
        hold(11'h000);
        cw(16'h0006);
        cw(16'h0007);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        repeat (60) @(posedge clk);
        tallyAndFinish();
    end
endmodule
